// File: amm_alarm_mute.sv
`timescale 1ns/1ns
module amm_alarm_mute #(
  parameter int unsigned FUSE_CYCLES = amm_pkg::FUSE_LOAD_CYC
) (
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_i,
  // Register access
  input  wire amm_pkg::amm_reg_req_t reg_req_i,
  output logic [7:0]                reg_rdata_o,
  output logic                      reg_rvalid_o,
  // Fault and link events
  input  wire amm_pkg::amm_events_t  events_i,
  // Alarm and mute outputs
  output logic                      alarm_o,
  output logic                      mute_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0]                       alarm;
    logic [7:0]                       out_mask;
    logic [7:0]                       mute_mask;
    logic [7:0]                       recovery;
    logic [7:0]                       fine_cur;
    logic [amm_pkg::FUSE_CNT_W-1:0]   fuse_cnt;
    amm_pkg::amm_fuse_st_t            fuse_st;
    logic                             alarm_out;
    logic                             mute_out;
    logic [7:0]                       rdata;
    logic                             rvalid;
  } amm_state_t;

  localparam logic [amm_pkg::FUSE_CNT_W-1:0] FUSE_END = amm_pkg::FUSE_CNT_W'(FUSE_CYCLES);

  amm_state_t st_reg;
  amm_state_t st_next;

  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic       wr_alarm;
  logic       mute_sysref;
  logic       mute_crc;
  logic       mute_link;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;

    // Hardware events; set outranks a software clear in the same cycle
    set_vec = 8'h00;
    set_vec[amm_pkg::BIT_LINK_DOWN] = events_i.link_down & events_i.link_enable;
    set_vec[amm_pkg::BIT_LTIMER]    = events_i.link_timer;
    set_vec[amm_pkg::BIT_CRC]       = events_i.crc_fault & events_i.mode_64b66b;
    set_vec[amm_pkg::BIT_SYSREF]    = events_i.sysref_align;
    wr_alarm = reg_req_i.wr && (reg_req_i.addr == amm_pkg::OFS_SYS_ALARM);
    clr_vec  = wr_alarm ? reg_req_i.wdata : 8'h00;
    st_next.alarm = ((st_reg.alarm & ~clr_vec) | set_vec) & amm_pkg::SYS_ALARM_IMPL;

    // Writes; all bits of the mask registers are storage, reserved ones included
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        amm_pkg::OFS_OUT_MASK:      st_next.out_mask  = reg_req_i.wdata;
        amm_pkg::OFS_MUTE_MASK:     st_next.mute_mask = reg_req_i.wdata;
        amm_pkg::OFS_MUTE_RECOVERY: st_next.recovery  = reg_req_i.wdata;
        amm_pkg::OFS_FINE_BIAS_A:   st_next.fine_cur  = reg_req_i.wdata & amm_pkg::FINE_CUR_IMPL;
        default: ;
      endcase
    end

    // Reads answer one cycle later; unmapped addresses read zero
    st_next.rvalid = reg_req_i.rd;
    st_next.rdata  = 8'h00;
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        amm_pkg::OFS_SYS_ALARM:  st_next.rdata = st_reg.alarm;
        amm_pkg::OFS_OUT_MASK:      st_next.rdata = st_reg.out_mask;
        amm_pkg::OFS_MUTE_MASK:     st_next.rdata = st_reg.mute_mask;
        amm_pkg::OFS_MUTE_RECOVERY: st_next.rdata = st_reg.recovery;
        amm_pkg::OFS_FUSE_STAT:
          st_next.rdata[amm_pkg::BIT_FUSE_DONE] = (st_reg.fuse_st == amm_pkg::FUSE_IDLE);
        amm_pkg::OFS_FINE_BIAS_A:   st_next.rdata = st_reg.fine_cur;
        default: st_next.rdata = 8'h00;
      endcase
    end

    // Fuse auto-load; nothing here blocks access, software must wait itself
    unique case (st_reg.fuse_st)
      amm_pkg::FUSE_LOAD: begin
        st_next.fuse_cnt = st_reg.fuse_cnt + 1'b1;
        if (st_reg.fuse_cnt >= FUSE_END - 1'b1) begin
          st_next.fuse_st = amm_pkg::FUSE_IDLE;
        end
      end
      amm_pkg::FUSE_IDLE: st_next.fuse_cnt = st_reg.fuse_cnt;
      default: st_next.fuse_st = amm_pkg::FUSE_LOAD;
    endcase

    // Alarm output; mask bits 4-2 are not looked at, bit 1 gates the reset alarm
    st_next.alarm_out =
      (st_reg.alarm[amm_pkg::BIT_LINK_DOWN] & ~st_reg.out_mask[amm_pkg::BIT_LINK_DOWN]) |
      (st_reg.alarm[amm_pkg::BIT_LTIMER]    & ~st_reg.out_mask[amm_pkg::BIT_LTIMER])    |
      (st_reg.alarm[amm_pkg::BIT_CRC]       & ~st_reg.out_mask[amm_pkg::BIT_CRC])       |
      (st_reg.alarm[amm_pkg::BIT_SYSRST]    & ~st_reg.out_mask[amm_pkg::BIT_SYSRST])    |
      (st_reg.alarm[amm_pkg::BIT_SYSREF]    & ~st_reg.out_mask[amm_pkg::BIT_SYSREF]);

    // Mute conditions
    mute_sysref = st_reg.alarm[amm_pkg::BIT_SYSREF]
                  & ~st_reg.mute_mask[amm_pkg::BIT_SYSREF];
    mute_crc    = ~st_reg.mute_mask[amm_pkg::BIT_CRC]
                  & (st_reg.recovery[amm_pkg::BIT_CRC_REC]
                     ? (events_i.crc_fault & events_i.mode_64b66b)
                     : st_reg.alarm[amm_pkg::BIT_CRC]);
    // Auto recovery gates the sticky alarm with the live link state: no mute while link_up
    mute_link   = st_reg.recovery[amm_pkg::BIT_LD_REC]
                  ? (st_reg.alarm[amm_pkg::BIT_LINK_DOWN] & ~events_i.link_up)
                  : st_reg.alarm[amm_pkg::BIT_LINK_DOWN];
    st_next.mute_out = mute_sysref | mute_crc | mute_link;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_reg           <= '0;
      st_reg.alarm     <= amm_pkg::RST_SYS_ALARM;
      st_reg.out_mask  <= amm_pkg::RST_OUT_MASK;
      st_reg.mute_mask <= amm_pkg::RST_MUTE_MASK;
      st_reg.recovery  <= amm_pkg::RST_MUTE_RECOVERY;
      st_reg.fine_cur  <= amm_pkg::RST_FINE_CUR;
      st_reg.fuse_st   <= amm_pkg::FUSE_LOAD;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o  = st_reg.rdata;
  assign reg_rvalid_o = st_reg.rvalid;
  assign alarm_o      = st_reg.alarm_out;
  assign mute_o       = st_reg.mute_out;

endmodule

// File: amm_pkg.sv
package amm_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_SYS_ALARM  = 12'h430;
  localparam logic [11:0] OFS_OUT_MASK      = 12'h431;
  localparam logic [11:0] OFS_MUTE_MASK     = 12'h432;
  localparam logic [11:0] OFS_MUTE_RECOVERY = 12'h433;
  localparam logic [11:0] OFS_FUSE_STAT     = 12'h600;
  localparam logic [11:0] OFS_FINE_BIAS_A   = 12'h723;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned BIT_LINK_DOWN = 7;
  localparam int unsigned BIT_LTIMER    = 6;
  localparam int unsigned BIT_CRC       = 5;
  localparam int unsigned BIT_SYSRST    = 1;
  localparam int unsigned BIT_SYSREF    = 0;
  localparam int unsigned BIT_LD_REC    = 7;
  localparam int unsigned BIT_CRC_REC   = 5;
  localparam int unsigned BIT_FUSE_DONE = 0;

  // Alarm bits that exist; bits 4-2 read as zero
  localparam logic [7:0] SYS_ALARM_IMPL = 8'hE3;
  localparam logic [7:0] FINE_CUR_IMPL  = 8'h3F;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_SYS_ALARM = 8'h02;
  localparam logic [7:0] RST_OUT_MASK      = 8'h00;
  localparam logic [7:0] RST_MUTE_MASK     = 8'h21;
  localparam logic [7:0] RST_MUTE_RECOVERY = 8'hA0;
  localparam logic [7:0] RST_FINE_CUR  = 8'h20;

  // ************************************************************
  // Fuse auto-load timing, in device clock cycles
  // ************************************************************
  localparam int unsigned FUSE_LOAD_LIMIT_CYC = 523000;
  localparam int unsigned FUSE_LOAD_CYC       = FUSE_LOAD_LIMIT_CYC - 1;
  localparam int unsigned FUSE_CNT_W          = 19;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    FUSE_LOAD = 2'h1,
    FUSE_IDLE = 2'h2
  } amm_fuse_st_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } amm_reg_req_t;

  typedef struct packed {
    logic link_down;
    logic link_timer;
    logic crc_fault;
    logic sysref_align;
    logic link_up;
    logic link_enable;
    logic mode_64b66b;
  } amm_events_t;

endpackage

// File: amm_alarm_mute_props.sv
`timescale 1ns/1ns
module amm_alarm_mute_chk #(
  parameter int unsigned FUSE_CYCLES = 20
) (
  // Clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  reset_i,
  // Register access
  input wire amm_pkg::amm_reg_req_t reg_req_i,
  input wire logic [7:0]            reg_rdata_o,
  input wire logic                  reg_rvalid_o,
  // Events and outputs
  input wire amm_pkg::amm_events_t  events_i,
  input wire logic                  alarm_o,
  input wire logic                  mute_o
);
  // ************************************************************
  // Shadow masks, rebuilt from port writes since the body is hidden
  // ************************************************************
  logic [7:0]  am_reg;
  logic [7:0]  mm_reg;
  logic [7:0]  rc_reg;
  logic [19:0] cnt_reg;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      am_reg  <= 8'h00;
      mm_reg  <= 8'h21;
      rc_reg  <= 8'hA0;
      cnt_reg <= 20'h00000;
    end else begin
      cnt_reg <= (cnt_reg == 20'hFFFFF) ? cnt_reg : cnt_reg + 20'h00001;
      if (reg_req_i.wr && reg_req_i.addr == amm_pkg::OFS_OUT_MASK) am_reg <= reg_req_i.wdata;
      if (reg_req_i.wr && reg_req_i.addr == amm_pkg::OFS_MUTE_MASK) mm_reg <= reg_req_i.wdata;
      if (reg_req_i.wr && reg_req_i.addr == amm_pkg::OFS_MUTE_RECOVERY) rc_reg <= reg_req_i.wdata;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  a_timer_alarm: assert property (
    events_i.link_timer && !am_reg[6] && !reg_req_i.wr |-> ##[1:2] alarm_o) else $error("no alarm");
  a_sysref_alarm: assert property (
    events_i.sysref_align && !am_reg[0] && !reg_req_i.wr |-> ##[1:2] alarm_o) else $error("no alarm");
  a_crc_mute: assert property (
    events_i.crc_fault && events_i.mode_64b66b && !mm_reg[5] && !reg_req_i.wr |-> ##[1:2] mute_o)
    else $error("no crc mute");
  a_sysref_mute: assert property (
    events_i.sysref_align && !mm_reg[0] && !reg_req_i.wr |-> ##[1:2] mute_o) else $error("no mute");
  a_link_hold_mute: assert property (
    events_i.link_down && events_i.link_enable && !rc_reg[7] && !reg_req_i.wr |-> ##[1:2] mute_o)
    else $error("no link mute");
  a_fuse_busy: assert property (
    reg_req_i.rd && reg_req_i.addr == amm_pkg::OFS_FUSE_STAT && cnt_reg + 2 < FUSE_CYCLES
    |=> !reg_rdata_o[0]) else $error("fuse done early");
  a_fuse_done: assert property (
    reg_req_i.rd && reg_req_i.addr == amm_pkg::OFS_FUSE_STAT && cnt_reg > FUSE_CYCLES + 1
    |=> reg_rvalid_o && reg_rdata_o[0]) else $error("fuse not done");
  a_all_masked: assert property (
    (am_reg == 8'hFF) [*2] |-> !alarm_o) else $error("alarm while masked");
  a_reset_quiet: assert property (
    disable iff (1'b0) reset_i |=> !alarm_o && !mute_o && !reg_rvalid_o) else $error("not quiet");
  c_unmute: cover property (mute_o ##1 !mute_o);
  c_both: cover property (alarm_o && mute_o);
  c_fuse: cover property (reg_rvalid_o && reg_rdata_o[0]);
endmodule
bind amm_alarm_mute amm_alarm_mute_chk #(.FUSE_CYCLES(FUSE_CYCLES)) u_chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .events_i(events_i), .alarm_o(alarm_o), .mute_o(mute_o));

// File: test_amm_alarm_mute.sv
`timescale 1ns/1ns
`define CHK(n, s, e) begin n_tests++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s: expected %0h seen %0h", n, e, s); end end
module test_amm_alarm_mute;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e;} amm_row_t;
  // Link up, enabled, 64b/66b, no faults
  localparam logic [6:0] BASE = 7'b0000111;
  logic                  clk_sys_i = 1'b0;
  logic                  reset_i   = 1'b1;
  amm_pkg::amm_reg_req_t reg_req_i = '0;
  amm_pkg::amm_events_t  events_i  = BASE;
  logic [7:0]            reg_rdata_o;
  logic                  reg_rvalid_o;
  logic                  alarm_o;
  logic                  mute_o;
  int                    errors    = 0;
  int                    n_tests   = 0;
  amm_row_t              rows [12] = '{
    '{1'b0, 12'h600, 8'h00, 8'h01}, '{1'b0, 12'h431, 8'h00, 8'h00},
    '{1'b0, 12'h432, 8'h00, 8'h21}, '{1'b0, 12'h433, 8'h00, 8'hA0},
    '{1'b0, 12'h430, 8'h00, 8'h02}, '{1'b0, 12'h723, 8'h00, 8'h20},
    '{1'b0, 12'h7FF, 8'h00, 8'h00}, '{1'b1, 12'h431, 8'h1E, 8'h1E},
    '{1'b1, 12'h723, 8'hFF, 8'h3F}, '{1'b1, 12'h433, 8'h5F, 8'h5F},
    '{1'b1, 12'h431, 8'h00, 8'h00}, '{1'b1, 12'h430, 8'hFF, 8'h00}};
  amm_alarm_mute #(.FUSE_CYCLES(20)) dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .events_i(events_i), .alarm_o(alarm_o), .mute_o(mute_o));
  always #20 clk_sys_i = ~clk_sys_i;
  // ************************************************************
  // Bus and event tasks
  // ************************************************************
  task automatic step();
    @(posedge clk_sys_i);
    #2;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    reg_req_i = '{1'b1, 1'b0, a, d};
    step();
    reg_req_i = '0;
    // Idle edge so back-to-back accesses never drive the strobe twice at once
    step();
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    reg_req_i = '{1'b0, 1'b1, a, 8'h00};
    step();
    reg_req_i = '0;
    `CHK("rvalid", reg_rvalid_o, 1'b1)
    `CHK("rdata", reg_rdata_o, e)
    step();
  endtask
  // One-cycle event, result checked three edges later, then a full clear must release both outputs
  task automatic ev_case(input logic [6:0] ev, input logic [7:0] am, mm, rc, input logic ea, em);
    wr_reg(amm_pkg::OFS_OUT_MASK, am);
    wr_reg(amm_pkg::OFS_MUTE_MASK, mm);
    wr_reg(amm_pkg::OFS_MUTE_RECOVERY, rc);
    events_i = ev;
    step();
    events_i = BASE;
    step();
    step();
    `CHK("alarm_o", alarm_o, ea)
    `CHK("mute_o", mute_o, em)
    wr_reg(amm_pkg::OFS_SYS_ALARM, 8'hFF);
    step();
    step();
    `CHK("alarm_o clr", alarm_o, 1'b0)
    `CHK("mute_o clr", mute_o, 1'b0)
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_i);
    #2;
    reset_i = 1'b0;
    rd_chk(amm_pkg::OFS_FUSE_STAT, 8'h00);
    // Fuse-backed registers stay untouched until the auto-load is over
    repeat (20) step();
    rd_chk(amm_pkg::OFS_FUSE_STAT, 8'h01);
    foreach (rows[i]) begin
      if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    repeat (20) step();
    wr_reg(amm_pkg::OFS_FUSE_STAT, 8'hFE);
    rd_chk(amm_pkg::OFS_FUSE_STAT, 8'h01);
    ev_case(7'b0001111, 8'h00, 8'h20, 8'hA0, 1'b1, 1'b1);
    ev_case(7'b0001111, 8'h01, 8'h21, 8'hA0, 1'b0, 1'b0);
    ev_case(7'b0010111, 8'h00, 8'h01, 8'h80, 1'b1, 1'b1);
    ev_case(7'b0010111, 8'h00, 8'h01, 8'hA0, 1'b1, 1'b0);
    ev_case(7'b0010111, 8'h20, 8'h21, 8'h80, 1'b0, 1'b0);
    ev_case(7'b0010110, 8'h00, 8'h01, 8'h80, 1'b0, 1'b0);
    ev_case(7'b0100111, 8'h00, 8'h21, 8'hA0, 1'b1, 1'b0);
    ev_case(7'b0100111, 8'h40, 8'h21, 8'hA0, 1'b0, 1'b0);
    ev_case(7'b1000011, 8'h00, 8'h21, 8'h20, 1'b1, 1'b1);
    ev_case(7'b1000011, 8'h80, 8'h21, 8'hA0, 1'b0, 1'b0);
    ev_case(7'b1111011, 8'hFF, 8'h21, 8'hA0, 1'b0, 1'b0);
    // Link held down long enough to mute, then released by recovery alone
    wr_reg(amm_pkg::OFS_OUT_MASK, 8'h00);
    wr_reg(amm_pkg::OFS_MUTE_RECOVERY, 8'hA0);
    events_i = 7'b1000011;
    repeat (3) step();
    `CHK("mute_o link down", mute_o, 1'b1)
    events_i = BASE;
    repeat (2) step();
    `CHK("mute_o link up", mute_o, 1'b0)
    `CHK("alarm_o link up", alarm_o, 1'b1)
    wr_reg(amm_pkg::OFS_SYS_ALARM, 8'hFF);
    // Reset in mid-run: outputs quiet, then the reset alarm shows
    reset_i = 1'b1;
    repeat (2) step();
    `CHK("alarm_o in reset", alarm_o, 1'b0)
    `CHK("mute_o in reset", mute_o, 1'b0)
    reset_i = 1'b0;
    step();
    `CHK("alarm_o after reset", alarm_o, 1'b1)
    rd_chk(amm_pkg::OFS_FUSE_STAT, 8'h00);
    rd_chk(amm_pkg::OFS_MUTE_MASK, 8'h21);
    complete_run();
  end
  // The run needs some 260 cycles; a hung handshake must not stall the job
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    errors++;
    complete_run();
  end
endmodule
